// [core/flash_cmd_pkg.sv]
// constants and types shared by the flash command sequencer
`default_nettype none
package flash_cmd_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_BITS = 20;
  localparam int DATA_BITS = 16;
  localparam int SECTOR_LSB = 12;
  localparam int SECTOR_MSB = 19;
  // unlock and query addresses, word mode and byte mode
  localparam logic [11:0] UNLOCK1_WORD = 12'h555;
  localparam logic [11:0] UNLOCK2_WORD = 12'h2AA;
  localparam logic [11:0] QUERY_WORD = 12'h055;
  localparam logic [11:0] UNLOCK1_BYTE = 12'hAAA;
  localparam logic [11:0] UNLOCK2_BYTE = 12'h555;
  localparam logic [11:0] QUERY_BYTE = 12'h0AA;
  // command data bytes
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] ID_DATA = 8'h90;
  localparam logic [7:0] OTP_ENTER_DATA = 8'h88;
  localparam logic [7:0] EXIT_DATA = 8'h00;
  localparam logic [7:0] QUERY_DATA = 8'h98;
  localparam logic [7:0] PROGRAM_DATA = 8'hA0;
  localparam logic [7:0] BYPASS_DATA = 8'h20;
  localparam logic [7:0] ERASE_SETUP_DATA = 8'h80;
  localparam logic [7:0] CHIP_ERASE_DATA = 8'h10;
  localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
  localparam logic [7:0] SUSPEND_DATA = 8'hB0;
  localparam logic [7:0] RESUME_DATA = 8'h30;
  localparam logic [7:0] RESET_DATA = 8'hF0;
  // bus cycle timing, least times rounded up to whole clocks; the read count also adds the sync stages
  localparam int ADDR_SETUP_NS = 100;
  localparam int STROBE_PULSE_NS = 100;
  localparam int STROBE_HOLD_NS = 100;
  localparam int READ_ACCESS_NS = 100;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] SETUP_CYC =
    4'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_CYC =
    4'((STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC =
    4'((STROBE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_CYC =
    4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  typedef enum logic [3:0] {
    CMD_READ, CMD_RESET, CMD_ID_ENTRY, CMD_OTP_ENTER, CMD_OTP_EXIT,
    CMD_QUERY, CMD_PROGRAM, CMD_BYPASS_ENTER, CMD_BYPASS_PROGRAM,
    CMD_BYPASS_EXIT, CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_ADD,
    CMD_SUSPEND, CMD_RESUME
  } cmd_type;
  typedef enum logic [2:0] {
    ADDR_ANY, ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_QUERY, ADDR_USER, ADDR_SECTOR
  } addr_sel_type;
  typedef struct packed {
    logic rd;
    logic userData;
    addr_sel_type sel;
    logic [7:0] code;
  } step_type;
endpackage
`default_nettype wire

// [core/flash_bus_cycle.sv]
// one timed read or write cycle on the flash pins
`default_nettype none
module flash_bus_cycle
  import flash_cmd_pkg::*;
#(
  parameter int AW = ADDR_BITS + 1
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // request from the sequencer
  input wire logic start,
  input wire logic rd,
  input wire logic [AW-1:0] addr,
  input wire logic [DATA_BITS-1:0] wdata,
  output logic done,
  output logic [DATA_BITS-1:0] rdata,
  // flash pins
  output logic [AW-2:0] flashAddr,
  output logic addrLsb,
  output logic [DATA_BITS-1:0] dqOut,
  output logic dqOe,
  input wire logic [DATA_BITS-1:0] dqIn,
  output logic ceN,
  output logic weN,
  output logic oeN
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} st_type;
  typedef struct packed {
    st_type st;
    logic [3:0] cnt;
    logic rd;
    logic [AW-1:0] addr;
    logic [DATA_BITS-1:0] dqOut;
    logic dqOe, ceN, weN, oeN, done;
    logic [DATA_BITS-1:0] sync1, sync2, rdata;
  } cyc_type;
  cyc_type cyc_reg, cyc_next;

  always_comb
  begin
    cyc_next = cyc_reg;
    cyc_next.done = 1'b0;
    cyc_next.sync1 = dqIn;
    cyc_next.sync2 = cyc_reg.sync1;
    unique case (cyc_reg.st)
      ST_IDLE:
        if (start)
        begin
          // address and data go out before any strobe falls [R10] [R11]
          cyc_next.st = ST_SETUP;
          cyc_next.rd = rd;
          cyc_next.addr = addr;
          cyc_next.dqOut = wdata;
          cyc_next.dqOe = !rd; // [R1]
          cyc_next.ceN = 1'b0;
          cyc_next.cnt = SETUP_CYC;
        end
      ST_SETUP:
        if (cyc_reg.cnt == 4'h1)
        begin
          cyc_next.st = ST_PULSE;
          cyc_next.weN = cyc_reg.rd;
          cyc_next.oeN = !cyc_reg.rd;
          cyc_next.cnt = cyc_reg.rd ? READ_CYC : PULSE_CYC;
        end
        else
          cyc_next.cnt = cyc_reg.cnt - 4'h1;
      ST_PULSE:
        if (cyc_reg.cnt == 4'h1)
        begin
          // data stays driven past the rising strobe [R11]
          cyc_next.st = ST_HOLD;
          cyc_next.weN = 1'b1;
          cyc_next.oeN = 1'b1;
          cyc_next.ceN = 1'b1;
          cyc_next.cnt = HOLD_CYC;
          if (cyc_reg.rd)
            cyc_next.rdata = cyc_reg.sync2;
        end
        else
          cyc_next.cnt = cyc_reg.cnt - 4'h1;
      ST_HOLD:
        if (cyc_reg.cnt == 4'h1)
        begin
          cyc_next.st = ST_IDLE;
          cyc_next.dqOe = 1'b0;
          cyc_next.done = 1'b1;
        end
        else
          cyc_next.cnt = cyc_reg.cnt - 4'h1;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cyc_reg <= '0;
      cyc_reg.st <= ST_IDLE;
      cyc_reg.ceN <= 1'b1;
      cyc_reg.weN <= 1'b1;
      cyc_reg.oeN <= 1'b1;
    end
    else
      cyc_reg <= cyc_next;
  end

  assign done = cyc_reg.done;
  assign rdata = cyc_reg.rdata;
  assign flashAddr = cyc_reg.addr[AW-1:1];
  assign addrLsb = cyc_reg.addr[0];
  assign dqOut = cyc_reg.dqOut;
  assign dqOe = cyc_reg.dqOe;
  assign ceN = cyc_reg.ceN;
  assign weN = cyc_reg.weN;
  assign oeN = cyc_reg.oeN;
endmodule
`default_nettype wire

// [core/flash_cmd_host.sv]
// host-side sequencer that issues flash command sequences on the pins
// Operation
// [R1] every sequence cycle is a write except array read and id fourth cycle
// [R2] upper data byte ignored in command cycles; host drives it zero
// [R3] high address bits ignored in command cycles except sector or program
// [R4] array reads need no unlock or command cycles before them
// [R5] one F0 write anywhere returns to array read; needed to leave id
// [R6] one-time region entry: AA, 55, 88 at unlock addresses
// [R7] one-time region exit: AA, 55, 90, then 00 anywhere
// [R8] query: 98 to 55 word or AA byte, only in read or id; host also accepts it in one-time region mode
// [R9] program: AA, 55, A0 at unlock addresses, then address with data
// [R10] program address latched at later falling edge of write or select
// [R11] program data latched at first rising edge of write or select
// [R12] bypass entry: AA, 55, 20 at unlock addresses
// [R13] bypass program: A0 anywhere then address and data, only in bypass
// [R14] bypass exit: 90 then 00 anywhere, or a single F0
// [R15] chip erase: AA, 55, 80, AA, 55, 10 at unlock addresses
// [R16] sector erase: AA, 55, 80, AA, 55, then sector address with 30
// [R17] during erase timeout further sectors added by single sector/30 write
// [R18] sector chosen by address bits 19 down to 12 only
// [R19] protect verify read returns 00 unprotected, 01 protected
// [R20] suspend: B0 anywhere, only during sector erase
// [R21] resume: 30 anywhere, only while suspended
// [R22] while sector erase runs, only suspend is accepted; host also accepts sector add at any point of the erase
// [R23] id allowed in suspend; leaving id returns to suspend
// [R24] mismatched partial sequence is abandoned, prior read mode kept
`default_nettype none
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = ADDR_BITS
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // user command port
  input wire logic cmdValid,
  input wire cmd_type cmdCode,
  input wire logic [ADDR_W:0] cmdAddr,
  input wire logic [DATA_BITS-1:0] cmdData,
  input wire logic byteMode,
  input wire logic eraseDone,
  output logic cmdReady,
  output logic cmdDone,
  output logic cmdRefused,
  output logic [DATA_BITS-1:0] readData,
  output logic readValid,
  // mode status
  output logic bypassActive,
  output logic eraseActive,
  output logic suspendActive,
  // flash pins
  output logic [ADDR_W-1:0] flashAddr,
  output logic addrLsb,
  output logic [DATA_BITS-1:0] dqOut,
  output logic dqOe,
  input wire logic [DATA_BITS-1:0] dqIn,
  output logic ceN,
  output logic weN,
  output logic oeN,
  output logic byteN
);
  if (ADDR_W < SECTOR_MSB + 1)
    $error("ADDR_W too small for sector field");

  typedef enum logic [2:0] {
    MODE_READ, MODE_ID, MODE_OTP, MODE_QUERY, MODE_BYPASS,
    MODE_ERASE, MODE_CHIP, MODE_SUSPEND
  } mode_type;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_type;
  typedef struct packed {
    mode_type mode;
    logic suspId;
    seq_type seq;
    cmd_type cmd;
    logic [2:0] idx;
    logic [ADDR_W:0] uAddr;
    logic [DATA_BITS-1:0] uData;
    logic byteMode, byteN;
    logic start, rd;
    logic [ADDR_W:0] addr;
    logic [DATA_BITS-1:0] wdata;
    logic ready, done, refused, rdValid, bypass, erase, susp;
    logic [DATA_BITS-1:0] rdData;
  } host_type;
  host_type h_reg, h_next;
  logic cycDone;
  logic [DATA_BITS-1:0] cycData;

  function automatic logic [2:0] seqLen(input cmd_type c);
    unique case (c)
      CMD_READ, CMD_RESET, CMD_QUERY, CMD_SECTOR_ADD,
      CMD_SUSPEND, CMD_RESUME: seqLen = 3'd1;
      CMD_BYPASS_PROGRAM, CMD_BYPASS_EXIT: seqLen = 3'd2;
      CMD_OTP_ENTER, CMD_BYPASS_ENTER: seqLen = 3'd3;
      CMD_ID_ENTRY, CMD_OTP_EXIT, CMD_PROGRAM: seqLen = 3'd4;
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE: seqLen = 3'd6;
    endcase
  endfunction

  function automatic step_type seqStep(input cmd_type c, input logic [2:0] i);
    step_type s;
    s = '{rd: 1'b0, userData: 1'b0, sel: ADDR_ANY, code: EXIT_DATA};
    unique case (c)
      CMD_READ: s = '{1'b1, 1'b0, ADDR_USER, EXIT_DATA}; // [R4]
      CMD_RESET: s.code = RESET_DATA; // [R5] [R14]
      CMD_QUERY: s = '{1'b0, 1'b0, ADDR_QUERY, QUERY_DATA}; // [R8]
      CMD_SECTOR_ADD: // [R17]
        s = '{1'b0, 1'b0, ADDR_SECTOR, SECTOR_ERASE_DATA};
      CMD_SUSPEND: s.code = SUSPEND_DATA; // [R20]
      CMD_RESUME: s.code = RESUME_DATA; // [R21]
      CMD_BYPASS_PROGRAM: // [R13]
        s = (i == 3'd0) ? '{1'b0, 1'b0, ADDR_ANY, PROGRAM_DATA}
                        : '{1'b0, 1'b1, ADDR_USER, EXIT_DATA};
      CMD_BYPASS_EXIT: s.code = (i == 3'd0) ? ID_DATA : EXIT_DATA; // [R14]
      default:
      begin
        // shared unlock prefix; erase repeats it after the setup byte
        s.sel = (i == 3'd1 || i == 3'd4) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
        s.code = (i == 3'd1 || i == 3'd4) ? UNLOCK2_DATA : UNLOCK1_DATA;
        if (i == 3'd2)
          unique case (c)
            CMD_ID_ENTRY, CMD_OTP_EXIT: s.code = ID_DATA;
            CMD_OTP_ENTER: s.code = OTP_ENTER_DATA; // [R6]
            CMD_PROGRAM: s.code = PROGRAM_DATA; // [R9]
            CMD_BYPASS_ENTER: s.code = BYPASS_DATA; // [R12]
            default: s.code = ERASE_SETUP_DATA; // [R15] [R16]
          endcase
        if (i == 3'd3)
          unique case (c)
            CMD_ID_ENTRY: s = '{1'b1, 1'b0, ADDR_USER, EXIT_DATA}; // [R1]
            CMD_OTP_EXIT: s = '{1'b0, 1'b0, ADDR_ANY, EXIT_DATA}; // [R7]
            CMD_PROGRAM: s = '{1'b0, 1'b1, ADDR_USER, EXIT_DATA}; // [R9]
            default: ;
          endcase
        if (i == 3'd5 && c == CMD_CHIP_ERASE)
          s.code = CHIP_ERASE_DATA; // [R15]
        if (i == 3'd5 && c == CMD_SECTOR_ERASE)
          s = '{1'b0, 1'b0, ADDR_SECTOR, SECTOR_ERASE_DATA}; // [R16]
      end
    endcase
    seqStep = s;
  endfunction

  function automatic logic [ADDR_W:0] stepAddr(input addr_sel_type sel,
    input logic bm, input logic [ADDR_W:0] ua);
    logic [ADDR_W:0] a;
    a = '0;
    unique case (sel)
      ADDR_ANY: a = '0;
      ADDR_UNLOCK1: a[11:0] = bm ? UNLOCK1_BYTE : {UNLOCK1_WORD[10:0], 1'b0};
      ADDR_UNLOCK2: a[11:0] = bm ? UNLOCK2_BYTE : {UNLOCK2_WORD[10:0], 1'b0};
      ADDR_QUERY: a[11:0] = bm ? QUERY_BYTE : {QUERY_WORD[10:0], 1'b0};
      ADDR_USER: a = ua;
      // only the sector field is carried; lower bits are left zero
      ADDR_SECTOR: a[SECTOR_MSB+1:SECTOR_LSB+1] =
        ua[SECTOR_MSB+1:SECTOR_LSB+1]; // [R18]
    endcase
    stepAddr = a; // [R3]
  endfunction

  function automatic logic allowed(input mode_type m, input cmd_type c);
    unique case (m)
      MODE_ERASE: allowed = c == CMD_READ || c == CMD_SUSPEND ||
        c == CMD_SECTOR_ADD; // [R22] [R17]
      MODE_CHIP: allowed = c == CMD_READ;
      MODE_SUSPEND: allowed = c == CMD_READ || c == CMD_PROGRAM ||
        c == CMD_ID_ENTRY || c == CMD_RESUME || c == CMD_RESET; // [R20] [R23]
      MODE_BYPASS: allowed = c == CMD_READ || c == CMD_BYPASS_PROGRAM ||
        c == CMD_BYPASS_EXIT || c == CMD_RESET; // [R13] [R14]
      MODE_ID: allowed = c == CMD_READ || c == CMD_RESET ||
        c == CMD_QUERY; // [R5] [R8]
      MODE_QUERY: allowed = c == CMD_READ || c == CMD_RESET;
      default: allowed = !(c == CMD_BYPASS_PROGRAM || c == CMD_BYPASS_EXIT ||
        c == CMD_SECTOR_ADD || c == CMD_SUSPEND || c == CMD_RESUME);
    endcase
  endfunction

  always_comb
  begin
    step_type st;
    st = seqStep(h_reg.cmd, h_reg.idx);
    h_next = h_reg;
    h_next.start = 1'b0;
    h_next.done = 1'b0;
    h_next.refused = 1'b0;
    h_next.rdValid = 1'b0;
    if (eraseDone && (h_reg.mode == MODE_ERASE || h_reg.mode == MODE_CHIP))
      h_next.mode = MODE_READ;
    unique case (h_reg.seq)
      SEQ_IDLE:
        if (cmdValid && h_reg.ready)
        begin
          h_next.ready = 1'b0;
          if (allowed(h_reg.mode, cmdCode))
          begin
            h_next.seq = SEQ_ISSUE;
            h_next.cmd = cmdCode;
            h_next.idx = 3'd0;
            h_next.uAddr = cmdAddr;
            h_next.uData = cmdData;
            h_next.byteMode = byteMode;
          end
          else
          begin
            // refused commands never reach the pins [R24]
            h_next.refused = 1'b1;
            h_next.ready = 1'b1;
          end
        end
      SEQ_ISSUE:
      begin
        h_next.start = 1'b1;
        h_next.rd = st.rd;
        h_next.addr = stepAddr(st.sel, h_reg.byteMode, h_reg.uAddr);
        // command bytes ride the low lane, upper lane zero [R2]
        h_next.wdata = st.userData ? h_reg.uData : {8'h00, st.code};
        h_next.seq = SEQ_WAIT;
      end
      SEQ_WAIT:
        if (cycDone)
        begin
          if (h_reg.rd)
          begin
            h_next.rdData = cycData; // [R19]
            h_next.rdValid = 1'b1;
          end
          if (h_reg.idx == seqLen(h_reg.cmd) - 3'd1)
          begin
            h_next.seq = SEQ_IDLE;
            h_next.ready = 1'b1;
            h_next.done = 1'b1;
            unique case (h_reg.cmd)
              CMD_RESET:
              begin
                h_next.mode = h_reg.suspId ? MODE_SUSPEND : MODE_READ; // [R23]
                h_next.suspId = 1'b0;
              end
              CMD_ID_ENTRY:
              begin
                h_next.suspId = h_reg.mode == MODE_SUSPEND; // [R23]
                h_next.mode = MODE_ID;
              end
              CMD_OTP_ENTER: h_next.mode = MODE_OTP;
              CMD_OTP_EXIT, CMD_BYPASS_EXIT: h_next.mode = MODE_READ;
              CMD_QUERY: h_next.mode = MODE_QUERY;
              CMD_BYPASS_ENTER: h_next.mode = MODE_BYPASS;
              CMD_CHIP_ERASE: h_next.mode = MODE_CHIP;
              CMD_SECTOR_ERASE, CMD_RESUME: h_next.mode = MODE_ERASE;
              CMD_SUSPEND: h_next.mode = MODE_SUSPEND;
              default: ;
            endcase
          end
          else
          begin
            h_next.idx = h_reg.idx + 3'd1;
            h_next.seq = SEQ_ISSUE;
          end
        end
      default: h_next.seq = SEQ_IDLE;
    endcase
    h_next.bypass = h_next.mode == MODE_BYPASS;
    h_next.erase = h_next.mode inside {MODE_ERASE, MODE_CHIP};
    h_next.susp = h_next.mode == MODE_SUSPEND || h_next.suspId;
    h_next.byteN = !h_next.byteMode;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      h_reg <= '0;
      h_reg.mode <= MODE_READ;
      h_reg.seq <= SEQ_IDLE;
      h_reg.cmd <= CMD_READ;
      h_reg.ready <= 1'b1;
      h_reg.byteN <= 1'b1;
    end
    else
      h_reg <= h_next;
  end

  flash_bus_cycle #(.AW(ADDR_W + 1)) cycle_u (
    .mclk(mclk), .sys_rst(sys_rst), .start(h_reg.start), .rd(h_reg.rd),
    .addr(h_reg.addr), .wdata(h_reg.wdata), .done(cycDone),
    .rdata(cycData), .flashAddr(flashAddr), .addrLsb(addrLsb),
    .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .ceN(ceN), .weN(weN),
    .oeN(oeN));

  assign cmdReady = h_reg.ready;
  assign cmdDone = h_reg.done;
  assign cmdRefused = h_reg.refused;
  assign readData = h_reg.rdData;
  assign readValid = h_reg.rdValid;
  assign bypassActive = h_reg.bypass;
  assign eraseActive = h_reg.erase;
  assign suspendActive = h_reg.susp;
  assign byteN = h_reg.byteN;
endmodule
`default_nettype wire

// [bench/flash_cmd_host_properties.sv]
// pin and handshake assertions for the flash command host
`default_nettype none
module flash_cmd_host_properties
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = ADDR_BITS
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // user side
  input wire logic cmdReady,
  input wire logic cmdDone,
  input wire logic cmdRefused,
  input wire logic bypassActive,
  input wire logic eraseActive,
  input wire logic suspendActive,
  // flash pins
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_BITS-1:0] dqOut,
  input wire logic dqOe,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_write_not_read: assert property (!weN |-> oeN && !ceN && dqOe)
    else $error("write strobe without select or with read");
  a_read_no_drive: assert property (!oeN |-> !dqOe && weN)
    else $error("host drives data during a read");
  a_read_width: assert property ($fell(oeN) |-> !oeN[*3] ##1 oeN)
    else $error("read strobe not three clocks wide");
  a_done_idle: assert property (cmdDone |->
    ceN && weN && oeN && !dqOe)
    else $error("sequence done while bus busy");
  a_addr_setup: assert property ($fell(weN) |->
    !$past(ceN) && $stable(flashAddr))
    else $error("address not set up before write strobe");
  a_addr_held: assert property (!weN |->
    $stable(flashAddr) && $stable(dqOut))
    else $error("address or data moved during write strobe");
  a_write_width: assert property ($fell(weN) |=> $rose(weN))
    else $error("write strobe not one clock wide");
  a_data_at_rise: assert property ($rose(weN) |->
    dqOe && ceN && $stable(dqOut))
    else $error("data not held at strobe rise");
  a_refuse_quiet: assert property (cmdRefused |->
    ceN && weN && oeN && !dqOe)
    else $error("refused command reached the pins");
  a_bypass_alone: assert property (bypassActive |->
    !eraseActive && !suspendActive)
    else $error("bypass flag with erase flags");
  a_reset_idle: assert property (disable iff (1'b0)
    sys_rst |=> cmdReady && ceN && weN && oeN)
    else $error("bus not idle after reset");
endmodule
bind flash_cmd_host flash_cmd_host_properties #(.ADDR_W(ADDR_W)) i_props (
  .mclk(mclk), .sys_rst(sys_rst), .cmdReady(cmdReady), .cmdDone(cmdDone),
  .cmdRefused(cmdRefused), .bypassActive(bypassActive),
  .eraseActive(eraseActive), .suspendActive(suspendActive),
  .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN), .weN(weN),
  .oeN(oeN));
`default_nettype wire

// [bench/flash_dev_model.sv]
// behavioural flash device answering the host's bus cycles
`default_nettype none
module flash_dev_model
  import flash_cmd_pkg::*;
(
  // flash pins
  input wire logic [19:0] flashAddr,
  input wire logic addrLsb,
  input wire logic [DATA_BITS-1:0] dqOut,
  input wire logic dqOe,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  output logic [DATA_BITS-1:0] dqIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [20:0] wrAddr[$];
  logic [15:0] wrData[$];
  logic [20:0] latchAddr;
  logic armed = 1'b0;
  logic idMode = 1'b0;
  int unlockStep = 0;
  logic [15:0] rdVal;
  // address taken at the later falling edge of write or select
  always @(negedge weN or negedge ceN)
  begin
    if (!weN && !ceN)
    begin
      latchAddr = {flashAddr, addrLsb};
      armed = 1'b1;
    end
  end
  // data at the first rising edge; only the low byte is decoded
  always @(posedge weN or posedge ceN)
  begin
    if (armed)
    begin
      armed = 1'b0;
      wrAddr.push_back(latchAddr);
      wrData.push_back(dqOut);
      idMode = (dqOut[7:0] == 8'h90 && unlockStep == 2) ? 1'b1 :
        (dqOut[7:0] == 8'hF0 || dqOut[7:0] == 8'h00) ? 1'b0 : idMode;
      unlockStep = (dqOut[7:0] == 8'hAA) ? 1 :
        (dqOut[7:0] == 8'h55 && unlockStep == 1) ? 2 : 0;
    end
  end
  assign rdVal = idMode ? {15'h0000, ^flashAddr[19:12]} :
    flashAddr[15:0] ^ 16'h5A3C;
  // a released bus shows the inverse, so stale data never passes
  assign dqIn = (!oeN && !ceN) ? rdVal : ~rdVal;
endmodule
`default_nettype wire

// [bench/flash_cmd_host_tb.sv]
// self-checking bench for the flash command host with a device model
`default_nettype none
module flash_cmd_host_tb
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int M_READ = 0, M_ID = 1, M_QUERY = 2, M_BYP = 3;
  localparam int M_ERASE = 4, M_CHIP = 5, M_SUSP = 6, M_OTP = 7;
  localparam logic [14:0] ALLOW [8] = '{15'h0CFF, 15'h0023, 15'h0003,
    15'h0303, 15'h3001, 15'h0001, 15'h4047, 15'h0CFF};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid = 1'b0;
  cmd_type cmdCode = CMD_READ;
  logic [20:0] cmdAddr = 21'h000000;
  logic [15:0] cmdData = 16'h0000;
  logic byteMode = 1'b0;
  logic eraseDone = 1'b0;
  logic cmdReady, cmdDone, cmdRefused, readValid, addrLsb, dqOe, ceN, weN;
  logic oeN, byteN, bypassActive, eraseActive, suspendActive;
  logic [15:0] readData, dqOut, dqIn;
  logic [19:0] flashAddr;
  int nMismatch = 0;
  int checksDone = 0;
  int cycles = 0;
  int mode = M_READ;
  logic fromSusp = 1'b0;
  logic devId = 1'b0;
  logic sawRead;
  logic [31:0] seed = 32'h0000005A;
  logic [20:0] expAddr[$];
  logic [20:0] expMask[$];
  logic [15:0] expData[$];
  int plan[] = '{0, 6, 8, 13, 14, 2, 5, 1, 5, 6, 1, 3, 0, 4, 7, 8, 8, 12, 9,
    7, 1, 10, 13, 0, 15, 11, 12, 12, 6, 14, 13, 2, 1, 6, 0, 14, 13, 14, 15};

  flash_cmd_host #(.ADDR_W(20)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .byteMode(byteMode), .eraseDone(eraseDone),
    .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdRefused(cmdRefused),
    .readData(readData), .readValid(readValid), .bypassActive(bypassActive),
    .eraseActive(eraseActive), .suspendActive(suspendActive),
    .flashAddr(flashAddr), .addrLsb(addrLsb), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(dqIn), .ceN(ceN), .weN(weN), .oeN(oeN), .byteN(byteN));
  flash_dev_model i_dev (.flashAddr(flashAddr), .addrLsb(addrLsb),
    .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN), .weN(weN), .oeN(oeN),
    .dqIn(dqIn));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] want);
    checksDone++;
    if (seen !== want)
    begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic endOfTest();
    if (nMismatch == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // kind: 0 any, 1 first unlock, 2 second unlock, 3 query, 4 user, 5 sector
  task automatic step(input int kind, input logic [15:0] d);
    logic [20:0] a;
    logic [20:0] m;
    case (kind)
      1: a = 21'h000AAA;
      2: a = byteMode ? 21'h000555 : 21'h000554;
      3: a = 21'h0000AA;
      4: a = cmdAddr;
      default: a = {cmdAddr[20:13], 13'h0000};
    endcase
    m = (kind == 0) ? 21'h000000 : (kind < 4) ? 21'h000FFF : 21'h1FFFFF;
    m[0] = m[0] & byteMode;
    expAddr.push_back(a);
    expMask.push_back(m);
    expData.push_back(d);
  endtask
  task automatic expectSeq(input cmd_type c);
    if (c inside {CMD_ID_ENTRY, CMD_OTP_ENTER, CMD_OTP_EXIT, CMD_PROGRAM,
      CMD_BYPASS_ENTER, CMD_CHIP_ERASE, CMD_SECTOR_ERASE})
    begin
      step(1, 16'h00AA);
      step(2, 16'h0055);
    end
    case (c)
      CMD_RESET: step(0, 16'h00F0);
      CMD_ID_ENTRY, CMD_OTP_EXIT: step(1, 16'h0090);
      CMD_OTP_ENTER: step(1, 16'h0088);
      CMD_QUERY: step(3, 16'h0098);
      CMD_PROGRAM: step(1, 16'h00A0);
      CMD_BYPASS_ENTER: step(1, 16'h0020);
      CMD_BYPASS_PROGRAM: step(0, 16'h00A0);
      CMD_BYPASS_EXIT: step(0, 16'h0090);
      CMD_SUSPEND: step(0, 16'h00B0);
      CMD_RESUME: step(0, 16'h0030);
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE: step(1, 16'h0080);
      default: ;
    endcase
    if (c inside {CMD_CHIP_ERASE, CMD_SECTOR_ERASE})
    begin
      step(1, 16'h00AA);
      step(2, 16'h0055);
    end
    case (c)
      CMD_OTP_EXIT, CMD_BYPASS_EXIT: step(0, 16'h0000);
      CMD_PROGRAM, CMD_BYPASS_PROGRAM: step(4, cmdData);
      CMD_CHIP_ERASE: step(1, 16'h0010);
      CMD_SECTOR_ERASE, CMD_SECTOR_ADD: step(5, 16'h0030);
      default: ;
    endcase
  endtask
  task automatic nextMode(input cmd_type c);
    if (c == CMD_ID_ENTRY)
      fromSusp = (mode == M_SUSP);
    if (c inside {CMD_RESET, CMD_OTP_EXIT, CMD_BYPASS_EXIT})
      devId = 1'b0;
    case (c)
      CMD_RESET: mode = (mode == M_ID && fromSusp) ? M_SUSP : M_READ;
      CMD_ID_ENTRY: mode = M_ID;
      CMD_OTP_ENTER: mode = M_OTP;
      CMD_OTP_EXIT, CMD_BYPASS_EXIT: mode = M_READ;
      CMD_QUERY: mode = M_QUERY;
      CMD_BYPASS_ENTER: mode = M_BYP;
      CMD_CHIP_ERASE: mode = M_CHIP;
      CMD_SECTOR_ERASE, CMD_RESUME: mode = M_ERASE;
      CMD_SUSPEND: mode = M_SUSP;
      default: ;
    endcase
  endtask
  task automatic finishErase();
    eraseDone = 1'b1;
    @(posedge mclk);
    #1;
    eraseDone = 1'b0;
    if (mode inside {M_ERASE, M_CHIP})
      mode = M_READ;
  endtask
  task automatic send(input cmd_type c);
    int k;
    logic ok;
    logic [20:0] m;
    ok = ALLOW[mode][c];
    @(posedge mclk);
    #1;
    check("bypassActive", bypassActive, mode == M_BYP);
    check("suspendActive", suspendActive,
      mode == M_SUSP || mode == M_ID && fromSusp);
    check("eraseActive", eraseActive,
      mode == M_ERASE || mode == M_CHIP);
    cmdCode = c;
    cmdValid = 1'b1;
    sawRead = 1'b0;
    k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      cmdValid = 1'b0;
      sawRead = sawRead | (readValid === 1'b1);
      k++;
    end
    while (k < 100 && cmdDone !== 1'b1 && cmdRefused !== 1'b1);
    check("cmdRefused", cmdRefused, !ok);
    check("cmdDone", cmdDone, ok);
    if (ok)
      expectSeq(c);
    check("writeCount", i_dev.wrAddr.size(), expAddr.size());
    while (expAddr.size() > 0 && i_dev.wrAddr.size() > 0)
    begin
      m = expMask.pop_front();
      check("writeAddr", i_dev.wrAddr.pop_front() & m,
        expAddr.pop_front() & m);
      check("writeData", i_dev.wrData.pop_front(), expData.pop_front());
    end
    i_dev.wrAddr.delete();
    i_dev.wrData.delete();
    expAddr.delete();
    expMask.delete();
    expData.delete();
    if (ok && (c == CMD_READ || c == CMD_ID_ENTRY))
    begin
      devId = devId | (c == CMD_ID_ENTRY);
      check("readValid", sawRead, 1'b1);
      check("readData", readData, devId ? 16'(^cmdAddr[20:13]) :
        cmdAddr[16:1] ^ 16'h5A3C);
    end
    if (ok)
      check("byteN", byteN, !byteMode);
    if (ok)
      nextMode(c);
  endtask
  task automatic run(input int p);
    seed = xorshift(seed);
    cmdAddr = seed[20:0];
    byteMode = seed[31];
    seed = xorshift(seed);
    cmdData = seed[15:0];
    if (p < 0 && seed[30:28] == 3'h0)
      finishErase();
    if (p < 0)
      p = int'(seed[27:24] % 4'hF);
    if (p == 15)
      finishErase();
    else if (p == CMD_QUERY && fromSusp && mode == M_ID)
      send(CMD_READ);
    else
      send(cmd_type'(p));
  endtask

  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // a hang counts as a failure; the full run needs far fewer cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nMismatch++;
      endOfTest();
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    foreach (plan[i])
      run(plan[i]);
    for (int i = 0; i < 80; i++)
      run(-1);
    endOfTest();
  end
endmodule
`default_nettype wire
